// *** design/iepd_top.sv ***
// interrupt enable, priority pick and idle/power-down pin control
// assumes one 25 MHz clock, ahb-lite master, core and sources on same clock
`timescale 1ns/1ps
`include "iepd_defs.svh"
module iepd_top (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// interrupt sources
	input wire logic [5:0] src_req,
	// core side
	input wire logic irq_ack,
	output logic irq_valid,
	output logic [2:0] irq_vector,
	output logic irq_level,
	output logic cpu_halt,
	output logic ram_retain,
	// pins
	input wire logic ext_prog_mem,
	input iepd_pkg::iepd_pins_t core_pins,
	input iepd_pkg::iepd_latch_t port_latch,
	output iepd_pkg::iepd_pins_t pins
);
	localparam logic [5:0] EXT_SRC = `IEPD_EXT_MASK;

	iepd_pkg::iepd_state_t s;
	iepd_pkg::iepd_state_t n;
	logic [5:0] acc;
	logic [4:0] pick;
	logic ap_take;
	logic ext_code;

	// lowest index wins in a level; high level overrides
	function automatic logic [4:0] iepd_pick_f(
		input logic [5:0] a,
		input logic [5:0] p
	);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 5; i >= 0; i--) begin
			if (a[i] && !p[i]) begin
				r = {1'b1, 1'b0, 3'(i)};
			end
		end
		for (int i = 5; i >= 0; i--) begin
			if (a[i] && p[i]) begin
				r = {1'b1, 1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : iepd_pick_f

	// per source gate; in power-down only outside irqs wake
	for (genvar g = 0; g < `IEPD_NSRC; g++) begin : g_acc
		assign acc[g] = src_req[g] && s.interrupt_enable_reg[g]
			&& s.interrupt_enable_reg[`IEPD_IE_GLOBAL]
			&& (s.mode != iepd_pkg::IEPD_SLEEP || EXT_SRC[g]);
	end

	assign pick = iepd_pick_f(acc, s.prio);
	assign ap_take = hsel && htrans[1] && hready;
	assign ext_code = s.ext_sync[1];

	always_comb begin
		n = s;
		n.ext_sync = {s.ext_sync[0], ext_prog_mem};
		// write data phase
		if (s.ap_valid && s.ap_write) begin
			if (s.ap_addr == `IEPD_IE_ADDR) begin
				n.interrupt_enable_reg = hwdata[7:0] & `IEPD_IE_WMASK;
			end else if (s.ap_addr == `IEPD_SET_ADDR) begin
				n.interrupt_enable_reg = s.interrupt_enable_reg
					| (hwdata[7:0] & `IEPD_IE_WMASK);
			end else if (s.ap_addr == `IEPD_CLR_ADDR) begin
				n.interrupt_enable_reg = s.interrupt_enable_reg
					& ~hwdata[7:0];
			end else if (s.ap_addr == `IEPD_PRIO_ADDR) begin
				n.prio = hwdata[5:0];
			end else if (s.ap_addr == `IEPD_PWR_ADDR) begin
				n.doze_request_bit = hwdata[`IEPD_PWR_DOZE];
				n.sleep_request_bit = hwdata[`IEPD_PWR_SLEEP];
				if (hwdata[`IEPD_PWR_SLEEP]) begin
					n.mode = iepd_pkg::IEPD_SLEEP;
				end else if (hwdata[`IEPD_PWR_DOZE]) begin
					n.mode = iepd_pkg::IEPD_DOZE;
				end
			end
		end
		// vector hand-off and wake
		if (s.irq_valid && irq_ack) begin
			n.irq_valid = 1'b0;
			n.doze_request_bit = 1'b0;
			n.sleep_request_bit = 1'b0;
			n.mode = iepd_pkg::IEPD_RUN;
		end else if (!s.irq_valid && pick[4]) begin
			n.irq_valid = 1'b1;
			n.lvl = pick[3];
			n.vec = pick[2:0];
		end
		if (s.mode != iepd_pkg::IEPD_RUN && (s.irq_valid || pick[4])) begin
			n.mode = iepd_pkg::IEPD_RUN;
		end
		// pin forcing
		case (s.mode)
			iepd_pkg::IEPD_RUN: begin
				n.pins = core_pins;
			end
			iepd_pkg::IEPD_DOZE: begin
				n.pins.addr_latch_strobe = 1'b1;
				n.pins.code_fetch_strobe = 1'b1;
				n.pins.p0_out = 8'h00;
				n.pins.p0_oe_n = ext_code ? 8'hff : port_latch.p0;
				n.pins.p1_out = port_latch.p1;
				n.pins.p2_out = ext_code ? s.pins.p2_out : port_latch.p2;
				n.pins.p3_out = port_latch.p3;
			end
			default: begin
				n.pins.addr_latch_strobe = 1'b0;
				n.pins.code_fetch_strobe = 1'b0;
				n.pins.p0_out = 8'h00;
				n.pins.p0_oe_n = ext_code ? 8'hff : port_latch.p0;
				n.pins.p1_out = port_latch.p1;
				n.pins.p2_out = port_latch.p2;
				n.pins.p3_out = port_latch.p3;
			end
		endcase
		// address phase and read data
		if (hready) begin
			n.ap_valid = ap_take && hsize == `IEPD_HSIZE_WORD;
			n.ap_write = hwrite;
			n.ap_addr = haddr[7:0];
			n.rdata = 32'h0000_0000;
			if (ap_take && !hwrite) begin
				if (haddr[7:0] == `IEPD_IE_ADDR) begin
					n.rdata = {24'h00_0000, n.interrupt_enable_reg};
				end else if (haddr[7:0] == `IEPD_PRIO_ADDR) begin
					n.rdata = {26'h000_0000, n.prio};
				end else if (haddr[7:0] == `IEPD_PWR_ADDR) begin
					n.rdata = {30'h0000_0000, n.sleep_request_bit,
						n.doze_request_bit};
				end else if (haddr[7:0] == `IEPD_STAT_ADDR) begin
					n.rdata = {19'h0_0000, n.mode, n.lvl, n.irq_valid,
						n.vec, acc};
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			s <= '0;
			s.interrupt_enable_reg <= `IEPD_IE_RESET;
			s.mode <= iepd_pkg::IEPD_RUN;
			s.pins.addr_latch_strobe <= 1'b1;
			s.pins.code_fetch_strobe <= 1'b1;
			s.pins.p0_oe_n <= 8'hff;
			s.pins.p1_out <= 8'hff;
			s.pins.p2_out <= 8'hff;
			s.pins.p3_out <= 8'hff;
		end else begin
			s <= n;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign irq_valid = s.irq_valid;
	assign irq_vector = s.vec;
	assign irq_level = s.lvl;
	assign cpu_halt = s.mode != iepd_pkg::IEPD_RUN;
	// ram clock/write gate held off only in power-down; reset returns to run and releases it
	assign ram_retain = s.mode == iepd_pkg::IEPD_SLEEP;
	assign pins = s.pins;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	sequence idle_no_irq_s;
		!s.irq_valid;
	endsequence
	sequence acked_s;
		s.irq_valid && irq_ack;
	endsequence

	reset_clears_a: assert property (disable iff (1'b0) !rstn |=>
		(s.interrupt_enable_reg == 8'h00 && !s.irq_valid
		&& s.mode == iepd_pkg::IEPD_RUN))
		else $error("reset did not clear enable state");
	global_gate_a: assert property (
		(idle_no_irq_s and !s.interrupt_enable_reg[7]) |=> !s.irq_valid)
		else $error("irq raised while global enable clear");
	hi_level_a: assert property (
		(idle_no_irq_s and (acc & s.prio) != 6'h00) |=>
		(s.irq_valid && s.lvl))
		else $error("high level request not chosen");
	poll_order_a: assert property (
		(idle_no_irq_s and (acc[0] && (s.prio[0]
		|| (acc & s.prio) == 6'h00))) |=> (s.irq_valid && s.vec == 3'h0))
		else $error("polling order broken");
	timer_mask_a: assert property (
		(idle_no_irq_s and (src_req == 6'h02
		&& !s.interrupt_enable_reg[`IEPD_IE_T0])) |=> !s.irq_valid)
		else $error("masked timer 0 raised irq");
	ext_enable_a: assert property (
		(idle_no_irq_s and (src_req[0] && s.interrupt_enable_reg[7]
		&& s.interrupt_enable_reg[`IEPD_IE_X0])) |=> s.irq_valid)
		else $error("enabled outside irq 0 not raised");
	vector_clears_a: assert property (acked_s |=>
		(!s.doze_request_bit && !s.sleep_request_bit
		&& s.mode == iepd_pkg::IEPD_RUN && !s.irq_valid))
		else $error("vectoring left request bits set");
	sleep_keeps_a: assert property (
		(s.mode == iepd_pkg::IEPD_SLEEP && !(s.ap_valid && s.ap_write))
		|=> $stable(s.interrupt_enable_reg) && $stable(s.prio))
		else $error("power-down exit changed registers");
	strobe_idle_a: assert property (
		s.mode == iepd_pkg::IEPD_DOZE |=>
		(pins.addr_latch_strobe && pins.code_fetch_strobe))
		else $error("strobes not high in idle");
	strobe_sleep_a: assert property (
		s.mode == iepd_pkg::IEPD_SLEEP |=>
		(!pins.addr_latch_strobe && !pins.code_fetch_strobe))
		else $error("strobes not low in power-down");
	port0_int_a: assert property (
		(s.mode != iepd_pkg::IEPD_RUN && !ext_code) |=>
		(pins.p0_out == 8'h00 && pins.p0_oe_n == $past(port_latch.p0)))
		else $error("port 0 not open-drain latch data");
	port_ext_a: assert property (
		(s.mode != iepd_pkg::IEPD_RUN && ext_code) |=>
		(pins.p0_oe_n == 8'hff && pins.p1_out == $past(port_latch.p1)))
		else $error("port 0 not floating with external code");
	no_preempt_a: assert property (
		(s.irq_valid && !irq_ack) |=>
		(s.irq_valid && $stable(s.vec) && $stable(s.lvl)))
		else $error("pending irq replaced before ack");
	clear_bits_a: assert property (
		(s.ap_valid && s.ap_write
		&& s.ap_addr == `IEPD_CLR_ADDR) |=>
		((s.interrupt_enable_reg & $past(hwdata[7:0])) == 8'h00))
		else $error("clear write left enable bits set");
	set_bits_a: assert property (
		(s.ap_valid && s.ap_write
		&& s.ap_addr == `IEPD_SET_ADDR) |=>
		((~s.interrupt_enable_reg & $past(hwdata[7:0])
		& `IEPD_IE_WMASK) == 8'h00))
		else $error("set write missed enable bits");
	reset_pins_a: assert property (disable iff (1'b0) !rstn |=>
		(pins.addr_latch_strobe && pins.code_fetch_strobe
		&& pins.p0_oe_n == 8'hff && !cpu_halt && !ram_retain))
		else $error("pins or modes not at reset values");
	sleep_retain_a: assert property (
		(s.ap_valid && s.ap_write && s.ap_addr == `IEPD_PWR_ADDR
		&& hwdata[`IEPD_PWR_SLEEP] && s.mode == iepd_pkg::IEPD_RUN
		&& !s.irq_valid) |=> ram_retain)
		else $error("ram not retained in power-down");
	both_bits_a: assert property (
		(s.ap_valid && s.ap_write && s.ap_addr == `IEPD_PWR_ADDR
		&& hwdata[1:0] == 2'h3 && !s.irq_valid)
		|=> s.mode != iepd_pkg::IEPD_DOZE)
		else $error("idle entered with both request bits");
	sleep_wake_a: assert property (
		(idle_no_irq_s and (s.mode == iepd_pkg::IEPD_SLEEP
		&& (src_req & EXT_SRC) == 6'h00)) |=> !s.irq_valid)
		else $error("non-outside irq woke power-down");
	p2_hold_a: assert property (
		(s.mode == iepd_pkg::IEPD_DOZE && ext_code) |=>
		$stable(pins.p2_out))
		else $error("port 2 address not held in idle");
	p2_sleep_a: assert property (
		s.mode == iepd_pkg::IEPD_SLEEP |=>
		pins.p2_out == $past(port_latch.p2))
		else $error("port 2 not port data in power-down");
	p13_latch_a: assert property (
		s.mode != iepd_pkg::IEPD_RUN |=>
		(pins.p1_out == $past(port_latch.p1)
		&& pins.p3_out == $past(port_latch.p3)))
		else $error("ports 1 and 3 lost port data");
endmodule : iepd_top

// *** design/iepd_defs.svh ***
// register map, field positions and reset values of the irq/low-power block
// assumes inclusion by the package and the top module only
`ifndef IEPD_DEFS_SVH
`define IEPD_DEFS_SVH
`define IEPD_IE_ADDR 8'ha8
`define IEPD_PWR_ADDR 8'hac
`define IEPD_PRIO_ADDR 8'hb0
`define IEPD_STAT_ADDR 8'hb4
`define IEPD_SET_ADDR 8'hb8
`define IEPD_CLR_ADDR 8'hbc
`define IEPD_IE_RESET 8'h00
`define IEPD_IE_WMASK 8'hbf
`define IEPD_IE_GLOBAL 7
`define IEPD_IE_T2 5
`define IEPD_IE_SER 4
`define IEPD_IE_T1 3
`define IEPD_IE_X1 2
`define IEPD_IE_T0 1
`define IEPD_IE_X0 0
`define IEPD_PWR_DOZE 0
`define IEPD_PWR_SLEEP 1
`define IEPD_EXT_MASK 6'h05
`define IEPD_NSRC 6
`define IEPD_HSIZE_WORD 3'h2
`endif

// *** design/iepd_pkg.sv ***
// types shared by the irq/low-power block
// assumes iepd_defs.svh for widths
`include "iepd_defs.svh"
package iepd_pkg;
	typedef enum logic [1:0] {
		IEPD_RUN = 2'h0,
		IEPD_DOZE = 2'h1,
		IEPD_SLEEP = 2'h3
	} iepd_mode_t;
	typedef struct packed {
		logic addr_latch_strobe;
		logic code_fetch_strobe;
		logic [7:0] p0_out;
		logic [7:0] p0_oe_n;
		logic [7:0] p1_out;
		logic [7:0] p2_out;
		logic [7:0] p3_out;
	} iepd_pins_t;
	typedef struct packed {
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
	} iepd_latch_t;
	typedef struct packed {
		logic [7:0] interrupt_enable_reg;
		logic [5:0] prio;
		logic doze_request_bit;
		logic sleep_request_bit;
		iepd_mode_t mode;
		logic irq_valid;
		logic [2:0] vec;
		logic lvl;
		logic [1:0] ext_sync;
		iepd_pins_t pins;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
	} iepd_state_t;
endpackage : iepd_pkg

// *** bench/iepd_core_model.sv ***
// core and source model: request levels, vectoring ack after a delay
// assumes the block's clock; the bench loads the request mask
`timescale 1ns/1ps
module iepd_core_model (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// from the block
	input wire logic irq_valid,
	input wire logic [2:0] irq_vector,
	// from the bench
	input wire logic load,
	input wire logic [5:0] want,
	input wire logic [3:0] ack_dly,
	// to the block
	output logic [5:0] src_req,
	output logic irq_ack
);
	logic [3:0] cnt;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			src_req <= 6'h00;
			irq_ack <= 1'b0;
			cnt <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			cnt <= 4'h0;
			// served source flag drops on vectoring
			if (load)
				src_req <= want;
			else if (irq_ack)
				src_req[irq_vector] <= 1'b0;
			if (irq_valid && !irq_ack) begin
				if (cnt == ack_dly)
					irq_ack <= 1'b1;
				else
					cnt <= cnt + 4'h1;
			end
		end
	end
endmodule : iepd_core_model

// *** bench/tb.sv ***
// self-checking bench for the irq enable and low-power block
// assumes the core model drives requests and acks
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, irq_ack, irq_valid, irq_level;
	logic cpu_halt, ram_retain, load = 1'b0, ext = 1'b0;
	logic [31:0] hrdata, rd;
	logic [5:0] src_req, want = 6'h00;
	logic [2:0] irq_vector;
	logic [3:0] ack_dly = 4'h0;
	iepd_pkg::iepd_pins_t pins;
	iepd_pkg::iepd_pins_t cpin = {2'h2, 40'h1100223344};
	iepd_pkg::iepd_latch_t lat = 32'h5ac3963c;
	int err_count = 0;
	int n_checks = 0;
	always #20 clock = ~clock;
	iepd_top dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .src_req(src_req), .irq_ack(irq_ack),
		.irq_valid(irq_valid), .irq_vector(irq_vector),
		.irq_level(irq_level), .cpu_halt(cpu_halt),
		.ram_retain(ram_retain), .ext_prog_mem(ext), .core_pins(cpin),
		.port_latch(lat), .pins(pins));
	iepd_core_model core (.clock(clock), .rstn(rstn),
		.irq_valid(irq_valid), .irq_vector(irq_vector), .load(load),
		.want(want), .ack_dly(ack_dly), .src_req(src_req),
		.irq_ack(irq_ack));
	task stop_test;
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task bad(input string m);
		$display("[FAIL] %0t %s", $time, m);
		err_count++;
	endtask : bad
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
			bad("value mismatch");
	endtask : chk
	task cp(input iepd_pkg::iepd_pins_t e);
		n_checks++;
		if (pins !== e)
			bad("pin mismatch");
	endtask : cp
	task rdy;
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (hreadyout === 1'b1)
				break;
		end
		if (i == 20) begin
			bad("bus hang");
			stop_test;
		end
	endtask : rdy
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		rd = hrdata;
	endtask : bus
	task wv(input logic v);
		int i;
		for (i = 0; i < 60; i++) begin
			@(posedge clock);
			#1;
			if (irq_valid === v)
				break;
		end
		if (i == 60) begin
			bad("irq wait");
			stop_test;
		end
	endtask : wv
	task req(input logic [5:0] w);
		@(posedge clock);
		load <= 1'b1;
		want <= w;
		@(posedge clock);
		load <= 1'b0;
	endtask : req
	task do_reset;
		rstn <= 1'b0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
	endtask : do_reset
	task t_regs;
		cp({2'h3, 40'h00ffffffff});
		bus(1'b1, 8'ha8, 32'hff);
		bus(1'b0, 8'ha8, 32'h0);
		chk(rd, 32'hbf);
		bus(1'b1, 8'hbc, 32'h0f);
		bus(1'b0, 8'ha8, 32'h0);
		chk(rd, 32'hb0);
		bus(1'b1, 8'hb8, 32'h4f);
		bus(1'b0, 8'ha8, 32'h0);
		chk(rd, 32'hbf);
		hsize <= 3'h0;
		bus(1'b1, 8'ha8, 32'h00);
		hsize <= 3'h2;
		bus(1'b0, 8'ha8, 32'h0);
		chk(rd, 32'hbf);
		chk({31'h0, hresp}, 32'h0);
		bus(1'b1, 8'hc0, 32'h12);
		bus(1'b0, 8'hc0, 32'h0);
		chk(rd, 32'h0);
		cp(cpin);
	endtask : t_regs
	task t_gate;
		int i;
		bus(1'b1, 8'ha8, 32'h3f);
		req(6'h3f);
		repeat (8) @(posedge clock);
		#1;
		chk({31'h0, irq_valid}, 32'h0);
		for (i = 0; i < 6; i++) begin
			bus(1'b1, 8'ha8, 32'h80 | (32'h1 << i));
			wv(1'b1);
			chk({29'h0, irq_vector}, 32'(i));
			wv(1'b0);
		end
	endtask : t_gate
	task t_ord(input logic [5:0] p, input logic [17:0] e);
		int i;
		bus(1'b1, 8'hb0, {26'h0, p});
		bus(1'b1, 8'ha8, 32'hbf);
		req(6'h3f);
		for (i = 0; i < 6; i++) begin
			wv(1'b1);
			chk({irq_level, irq_vector}, {p[e[3*i+:3]], e[3*i+:3]});
			wv(1'b0);
		end
	endtask : t_ord
	task t_lp(input logic x, input logic [1:0] m,
		input iepd_pkg::iepd_pins_t e);
		ext <= x;
		bus(1'b1, 8'ha8, 32'h81);
		bus(1'b1, 8'hac, {30'h0, m});
		repeat (2) @(posedge clock);
		#1;
		cp(e);
		chk({ram_retain, cpu_halt}, {m[1], 1'b1});
		bus(1'b0, 8'hb4, 32'h0);
		chk({rd[12:11], rd[9], rd[5:0]}, {m[1], 1'b1, 7'h00});
		req(6'h01);
		wv(1'b1);
		wv(1'b0);
		bus(1'b0, 8'hac, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'ha8, 32'h0);
		chk(rd, 32'h81);
		bus(1'b0, 8'hb0, 32'h0);
		chk(rd, 32'h28);
		chk({31'h0, cpu_halt}, 32'h0);
	endtask : t_lp
	task t_rst;
		bus(1'b1, 8'ha8, 32'h81);
		bus(1'b1, 8'hac, 32'h2);
		do_reset;
		cp({2'h3, 40'h00ffffffff});
		bus(1'b0, 8'ha8, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'hb0, 32'h0);
		chk(rd, 32'h0);
		chk({ram_retain, cpu_halt}, 2'h0);
	endtask : t_rst
	initial begin
		do_reset;
		t_regs;
		t_gate;
		t_ord(6'h00, 18'o543210);
		ack_dly <= 4'h6;
		t_ord(6'h28, 18'o421053);
		t_lp(1'b0, 2'h1, {2'h3, 40'h005ac3963c});
		t_lp(1'b1, 2'h1, {2'h3, 40'h00ffc3333c});
		t_lp(1'b0, 2'h3, {2'h0, 40'h005ac3963c});
		t_lp(1'b1, 2'h2, {2'h0, 40'h00ffc3963c});
		t_rst;
		stop_test;
	end
endmodule : tb
